/* core/hsp_bank_mem.sv */
// one pattern fifo bank: simple dual port memory with registered read data
`timescale 1ns/1ps
module hsp_bank_mem #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  // write port, guarded against addresses past the last entry
  always_ff @(posedge sys_clk_i) begin
    if (we_i && (int'(waddr_i) < DEPTH)) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge sys_clk_i) begin
    if (int'(raddr_i) < DEPTH) begin
      rdata_o <= mem_r[raddr_i];
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

/* core/hsp_fifo_load.sv */
// two bank timing pattern fifo: apb loading, loop length and pattern outputs
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module hsp_fifo_load
  import hsp_pkg::*;
#(
  parameter int DEPTH = HSP_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic advance_i,
  input wire logic match_i,
  output logic [15:0] next_timing_o,
  output logic adc_trigger_o,
  output logic irq_strobe_o,
  output logic narrow_head_o,
  output logic video_head_o,
  output logic audio_head_o,
  output logic extra_v_pulse_o,
  output logic extra_v_level_o,
  output logic [7:0] port_pattern_o,
  output logic irq_req_o
);
  localparam int EW = HSP_PAT_W + HSP_TIM_W;

  logic [7:0] loop_stage_count_r;
  logic [2:0] mode_r;
  logic [HSP_PAT_W-1:0] bank1_output_pattern_buffer_r;
  logic [HSP_PAT_W-1:0] bank2_output_pattern_buffer_r;
  logic [3:0] wptr1_r;
  logic [3:0] wptr2_r;
  logic [3:0] stage_r;
  logic [3:0] stage_nxt;
  hsp_play_t state_r;
  hsp_play_t state_nxt;
  logic [HSP_PAT_W-1:0] out_pat_r;
  logic strobe_prev_r;
  logic [EW-1:0] rd1;
  logic [EW-1:0] rd2;
  logic [EW-1:0] cur;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic acc;
  logic wr;
  logic full_word;
  logic wr_tw1;
  logic wr_tw2;
  logic mode_wr;
  logic loop_sel;
  logic bank_sel;
  logic [3:0] len1;
  logic [3:0] len2;
  logic [3:0] len_sel;
  logic [3:0] wptr_sel;

  // clamp a loop length code; prohibited codes act as the longest loop
  function automatic logic [3:0] clamp_len(input logic [3:0] code);
    clamp_len = (code > HSP_LEN_MAX) ? HSP_LEN_MAX : code;
  endfunction

  // known offset check
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == HSP_OFS_LOOP_STAGE_COUNT) || (a == HSP_OFS_MODE) ||
                (a == HSP_OFS_BANK1_PAT_BUF) || (a == HSP_OFS_BANK2_PAT_BUF) ||
                (a == HSP_OFS_BANK1_TIMING) || (a == HSP_OFS_BANK2_TIMING) ||
                (a == HSP_OFS_STATUS);
  endfunction

  // bus decode; a transfer completes in the access phase with pready high
  assign acc = psel_i && penable_i && pready_o;
  assign wr = acc && pwrite_i;
  assign full_word = (pstrb_i[1:0] == 2'h3);
  assign wr_tw1 = wr && full_word && (paddr_i == HSP_OFS_BANK1_TIMING);
  assign wr_tw2 = wr && full_word && (paddr_i == HSP_OFS_BANK2_TIMING);
  assign mode_wr = wr && pstrb_i[0] && (paddr_i == HSP_OFS_MODE);
  assign loop_sel = mode_r[HSP_MODE_LOOP_BIT];
  assign bank_sel = mode_r[HSP_MODE_BANK_BIT];
  assign len2 = clamp_len(loop_stage_count_r[HSP_BANK2_LEN_LSB +: 4]);
  assign len1 = clamp_len(loop_stage_count_r[HSP_BANK1_LEN_LSB +: 4]);
  assign len_sel = bank_sel ? len2 : len1;
  assign wptr_sel = bank_sel ? wptr2_r : wptr1_r;
  assign cur = bank_sel ? rd2 : rd1;

  // ready and read data are registered in the setup cycle
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = !is_mapped(paddr_i);
    case (paddr_i)
      HSP_OFS_LOOP_STAGE_COUNT: rdata_nxt = {24'h00_0000, loop_stage_count_r};
      HSP_OFS_MODE: rdata_nxt = {29'h0000_0000, mode_r};
      HSP_OFS_STATUS: rdata_nxt = {15'h0000, state_r == HSP_PLAY, stage_r, 4'h0, wptr2_r, wptr1_r};
      // buffers read as zero, no side effect
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // apb answer flops
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      if (psel_i && !penable_i) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
        pslverr_o <= err_nxt;
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // stage count register, never reset
  always_ff @(posedge sys_clk_i) begin
    if (wr && pstrb_i[0] && paddr_i == HSP_OFS_LOOP_STAGE_COUNT) begin
      loop_stage_count_r <= pwdata_i[7:0];
    end
  end

  // mode register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      mode_r <= HSP_MODE_RESET;
    end else if (mode_wr) begin
      mode_r <= pwdata_i[2:0];
    end
  end

  // pattern holding buffers, never reset
  always_ff @(posedge sys_clk_i) begin
    if (wr && full_word && paddr_i == HSP_OFS_BANK1_PAT_BUF) begin
      bank1_output_pattern_buffer_r <= pwdata_i[HSP_PAT_W-1:0];
    end
    if (wr && full_word && paddr_i == HSP_OFS_BANK2_PAT_BUF) begin
      bank2_output_pattern_buffer_r <= pwdata_i[HSP_PAT_W-1:0];
    end
  end

  // write pointers; writes to a full bank are dropped
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wptr1_r <= 4'h0;
      wptr2_r <= 4'h0;
    end else if (mode_wr && (pwdata_i[HSP_MODE_LOOP_BIT] != loop_sel)) begin
      wptr1_r <= 4'h0;
      wptr2_r <= 4'h0;
    end else begin
      if (wr_tw1 && int'(wptr1_r) < DEPTH) begin
        wptr1_r <= wptr1_r + 4'h1;
      end
      if (wr_tw2 && int'(wptr2_r) < DEPTH) begin
        wptr2_r <= wptr2_r + 4'h1;
      end
    end
  end

  // bank 1 commit of pattern and timing
  hsp_bank_mem #(.WIDTH(EW), .DEPTH(DEPTH), .AW(4)) u_bank1 (
    .sys_clk_i(sys_clk_i),
    .we_i(wr_tw1),
    .waddr_i(wptr1_r),
    .wdata_i({bank1_output_pattern_buffer_r, pwdata_i[15:0]}),
    .raddr_i(stage_r),
    .rdata_o(rd1)
  );

  // bank 2 commit of pattern and timing
  hsp_bank_mem #(.WIDTH(EW), .DEPTH(DEPTH), .AW(4)) u_bank2 (
    .sys_clk_i(sys_clk_i),
    .we_i(wr_tw2),
    .waddr_i(wptr2_r),
    .wdata_i({bank2_output_pattern_buffer_r, pwdata_i[15:0]}),
    .raddr_i(stage_r),
    .rdata_o(rd2)
  );

  // playback state and next stage
  always_comb begin
    stage_nxt = stage_r;
    // loop lengths used only in loop mode
    if (loop_sel) begin
      state_nxt = HSP_PLAY;
    end else if (stage_r < wptr_sel) begin
      state_nxt = HSP_PLAY;
    end else begin
      state_nxt = HSP_HOLD;
    end
    case (state_r)
      HSP_PLAY: begin
        if (advance_i) begin
          if (loop_sel && stage_r >= len_sel) begin
            stage_nxt = 4'h0;
          end else begin
            stage_nxt = stage_r + 4'h1;
          end
        end
      end
      HSP_HOLD: stage_nxt = stage_r;
      default: stage_nxt = 4'h0;
    endcase
  end

  // stage pointer restarts on mode or bank change
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      stage_r <= 4'h0;
      state_r <= HSP_HOLD;
    end else if (mode_wr) begin
      stage_r <= 4'h0;
      state_r <= HSP_HOLD;
    end else begin
      stage_r <= stage_nxt;
      state_r <= state_nxt;
    end
  end

  // output pattern register; kept across mode rewrites
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      out_pat_r <= HSP_PAT_RESET;
      next_timing_o <= 16'h0000;
    end else begin
      next_timing_o <= cur[HSP_TIM_W-1:0];
      if (advance_i && state_r == HSP_PLAY && !mode_wr) begin
        out_pat_r <= cur[EW-1:HSP_TIM_W];
      end
    end
  end

  // pattern fields onto the pins
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      adc_trigger_o <= 1'b0;
      irq_strobe_o <= 1'b0;
      narrow_head_o <= 1'b0;
      video_head_o <= 1'b0;
      audio_head_o <= 1'b0;
      extra_v_pulse_o <= 1'b0;
      extra_v_level_o <= 1'b0;
      port_pattern_o <= 8'h00;
    end else begin
      adc_trigger_o <= out_pat_r[HSP_PAT_ADC_BIT];
      irq_strobe_o <= out_pat_r[HSP_PAT_STROBE_BIT];
      narrow_head_o <= out_pat_r[HSP_PAT_NARROW_BIT];
      video_head_o <= out_pat_r[HSP_PAT_VIDEO_BIT];
      audio_head_o <= out_pat_r[HSP_PAT_AUDIO_BIT];
      extra_v_pulse_o <= out_pat_r[HSP_PAT_VPULSE_BIT];
      extra_v_level_o <= out_pat_r[HSP_PAT_VLEVEL_BIT];
      port_pattern_o <= out_pat_r[7:0];
    end
  end

  // interrupt request: strobe rising edge pulse, or the registered match input when match is selected
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      strobe_prev_r <= 1'b0;
      irq_req_o <= 1'b0;
    end else begin
      strobe_prev_r <= out_pat_r[HSP_PAT_STROBE_BIT];
      if (mode_r[HSP_MODE_IRQSEL_BIT]) begin
        irq_req_o <= match_i;
      end else begin
        irq_req_o <= out_pat_r[HSP_PAT_STROBE_BIT] && !strobe_prev_r;
      end
    end
  end

  // checks
  a_mode_reset: assert property (@(posedge sys_clk_i)
    $rose(resetn_i) |-> !loop_sel) else $error("mode not single after reset");
  a_ptr_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mode_wr && (pwdata_i[0] != loop_sel) |=> (wptr1_r == 4'h0) && (wptr2_r == 4'h0) && $stable(out_pat_r))
    else $error("mode rewrite did not clear pointers");
  a_bank1_commit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr_tw1 && wptr1_r < 4'hA && !mode_wr |=> wptr1_r == $past(wptr1_r) + 4'h1)
    else $error("bank 1 pointer did not advance");
  a_bank2_commit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr_tw2 && wptr2_r < 4'hA |=> wptr2_r == $past(wptr2_r) + 4'h1)
    else $error("bank 2 pointer did not advance");
  a_ptr_limit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wptr1_r <= 4'hA && wptr2_r <= 4'hA) else $error("write pointer past last entry");
  a_buf_read: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    psel_i && !penable_i && !pwrite_i && paddr_i == HSP_OFS_BANK1_PAT_BUF |=> prdata_o == 32'h0)
    else $error("pattern buffer read not zero");
  a_loop_wrap: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == HSP_PLAY && loop_sel && advance_i && !mode_wr && stage_r >= len_sel |=> stage_r == 4'h0)
    else $error("loop did not wrap");
  a_single_run: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !loop_sel && state_r == HSP_PLAY && advance_i && !mode_wr |=> stage_r == $past(stage_r) + 4'h1)
    else $error("single mode stage wrong");
  a_adc_out: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> adc_trigger_o == $past(out_pat_r[HSP_PAT_ADC_BIT])) else $error("adc trigger mismatch");
  a_irq_strobe: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !mode_r[1] && out_pat_r[13] && !strobe_prev_r |=> irq_req_o) else $error("strobe edge missed");
  a_irq_match: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mode_r[1] && !mode_wr ##1 mode_r[1] |-> irq_req_o == $past(match_i)) else $error("match irq wrong");
  // pin mapping, buffer, loop length and held pattern checks
  a_head_map: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> {narrow_head_o, video_head_o, audio_head_o} == $past(out_pat_r[HSP_PAT_NARROW_BIT:HSP_PAT_AUDIO_BIT]))
    else $error("head control mismatch");
  a_vsig_map: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> {extra_v_pulse_o, extra_v_level_o} == $past(out_pat_r[HSP_PAT_VPULSE_BIT:HSP_PAT_VLEVEL_BIT]))
    else $error("extra vertical control mismatch");
  a_port_map: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> port_pattern_o == $past(out_pat_r[7:0]))
    else $error("pulse port mismatch");
  a_strobe_pin: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> irq_strobe_o == $past(out_pat_r[HSP_PAT_STROBE_BIT]))
    else $error("strobe pin mismatch");
  a_buf_word: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && !full_word && (paddr_i == HSP_OFS_BANK1_PAT_BUF) |=> $stable(bank1_output_pattern_buffer_r))
    else $error("byte write changed pattern buffer");
  a_len_bank1: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    loop_sel |-> len1 <= HSP_LEN_MAX)
    else $error("bank 1 loop length out of range");
  a_len_bank2: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    loop_sel |-> len2 <= HSP_LEN_MAX)
    else $error("bank 2 loop length out of range");
  a_hold_kept: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    state_r == HSP_HOLD |=> $stable(out_pat_r))
    else $error("held pattern changed");
endmodule

/* core/hsp_pkg.sv */
// package: register map, fields and playback types for the pattern fifo loader
package hsp_pkg;
  // register byte offsets
  localparam logic [7:0] HSP_OFS_LOOP_STAGE_COUNT = 8'h00;
  localparam logic [7:0] HSP_OFS_MODE = 8'h04;
  localparam logic [7:0] HSP_OFS_BANK1_PAT_BUF = 8'h08;
  localparam logic [7:0] HSP_OFS_BANK2_PAT_BUF = 8'h0C;
  localparam logic [7:0] HSP_OFS_BANK1_TIMING = 8'h10;
  localparam logic [7:0] HSP_OFS_BANK2_TIMING = 8'h14;
  localparam logic [7:0] HSP_OFS_STATUS = 8'h18;
  // loop stage count fields
  localparam int HSP_BANK1_LEN_LSB = 0;
  localparam int HSP_BANK2_LEN_LSB = 4;
  localparam logic [3:0] HSP_LEN_MAX = 4'h9;
  // mode register fields
  localparam int HSP_MODE_LOOP_BIT = 0;
  localparam int HSP_MODE_IRQSEL_BIT = 1;
  localparam int HSP_MODE_BANK_BIT = 2;
  localparam logic [2:0] HSP_MODE_RESET = 3'h0;
  // pattern field positions
  localparam int HSP_PAT_ADC_BIT = 14;
  localparam int HSP_PAT_STROBE_BIT = 13;
  localparam int HSP_PAT_NARROW_BIT = 12;
  localparam int HSP_PAT_VIDEO_BIT = 11;
  localparam int HSP_PAT_AUDIO_BIT = 10;
  localparam int HSP_PAT_VPULSE_BIT = 9;
  localparam int HSP_PAT_VLEVEL_BIT = 8;
  localparam int HSP_PAT_W = 15;
  localparam int HSP_TIM_W = 16;
  localparam int HSP_DEPTH = 10;
  localparam logic [14:0] HSP_PAT_RESET = 15'h0000;
  // playback state
  typedef enum logic {HSP_HOLD, HSP_PLAY} hsp_play_t;
endpackage

/* test/hsp_fifo_load_test.sv */
// self-checking bench for the two bank pattern fifo loader
`timescale 1ns/1ps
module hsp_fifo_load_test;
  import hsp_pkg::*;
  typedef struct packed {logic [32:0] val; logic [32:0] msk;} hsp_note_t;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, advance_i = 1'b0, match_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic [31:0] prdata_o;
  logic [15:0] next_timing_o;
  logic [7:0] port_pattern_o;
  logic pready_o, pslverr_o, adc_trigger_o, irq_strobe_o, narrow_head_o, video_head_o, audio_head_o;
  logic extra_v_pulse_o, extra_v_level_o, irq_req_o;
  logic [2:0] adv_sh = 3'h0;
  logic [14:0] mem [2][10];
  logic [15:0] tm [2][10];
  logic [3:0] wp [2];
  logic [14:0] last;
  logic [15:0] p;
  int n_mismatch = 0;
  int compares = 0;
  int seed_v;
  hsp_note_t notes[$];

  hsp_fifo_load #(.DEPTH(HSP_DEPTH)) dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .advance_i(advance_i), .match_i(match_i),
    .next_timing_o(next_timing_o), .adc_trigger_o(adc_trigger_o), .irq_strobe_o(irq_strobe_o),
    .narrow_head_o(narrow_head_o), .video_head_o(video_head_o), .audio_head_o(audio_head_o),
    .extra_v_pulse_o(extra_v_pulse_o), .extra_v_level_o(extra_v_level_o), .port_pattern_o(port_pattern_o),
    .irq_req_o(irq_req_o));

  // 25 MHz system clock
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // pairs an observed result with the oldest note
  task automatic take(input logic [32:0] seen);
    hsp_note_t n;
    if (notes.size() == 0) begin
      chk(seen, ~seen);
    end else begin
      n = notes.pop_front();
      chk(seen & n.msk, n.val & n.msk);
    end
  endtask

  // watcher: apb read answers, pins while the request pulse stands, then the next timing word
  always @(posedge sys_clk_i) begin
    adv_sh <= {adv_sh[1:0], advance_i};
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) take({pslverr_o, prdata_o});
    if (adv_sh[1]) take({17'h0, irq_req_o, adc_trigger_o, irq_strobe_o, narrow_head_o, video_head_o,
      audio_head_o, extra_v_pulse_o, extra_v_level_o, port_pattern_o});
    if (adv_sh[2]) take({17'h0, next_timing_o});
  end

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // hold the access phase until pready; only the watchdog ends a hang
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    bus(a, 1'b1, d, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m = 33'h0_FFFF_FFFF);
    notes.push_back('{v, m});
    bus(a, 1'b0, 32'h0, 4'hF);
  endtask

  // mode write; a changed loop select clears both write pointers
  task automatic mode(input logic [2:0] v, input logic was_loop);
    wr(HSP_OFS_MODE, {29'h0, v});
    if (v[HSP_MODE_LOOP_BIT] != was_loop) wp = '{4'h0, 4'h0};
    repeat (2) @(posedge sys_clk_i);
  endtask

  task automatic load(input int b, input logic [15:0] pat, input logic bad);
    logic [31:0] t;
    t = $urandom;
    wr(b ? HSP_OFS_BANK2_PAT_BUF : HSP_OFS_BANK1_PAT_BUF, {16'h0, pat});
    if (bad) wr(HSP_OFS_BANK1_PAT_BUF, {16'h0, ~pat}, 4'h1);
    wr(b ? HSP_OFS_BANK2_TIMING : HSP_OFS_BANK1_TIMING, t);
    if (wp[b] < HSP_DEPTH) begin
      mem[b][wp[b]] = pat[14:0];
      tm[b][wp[b]] = t[15:0];
      wp[b]++;
    end
  endtask

  // one advance pulse; expect pattern pe on the pins and the request level
  task automatic play(input logic [14:0] pe, input logic isel, input int b, input int s);
    logic m;
    logic irq;
    m = 1'($urandom);
    irq = isel ? m : (!last[HSP_PAT_STROBE_BIT] && pe[HSP_PAT_STROBE_BIT]);
    notes.push_back('{{17'h0, irq, pe}, 33'h0_0000_FFFF});
    // timing word of the newly selected stage, unwritten entries masked
    notes.push_back('{{17'h0, tm[b][s]}, (s < wp[b]) ? 33'h0_0000_FFFF : 33'h0});
    last = pe;
    advance_i <= 1'b1;
    match_i <= m;
    @(posedge sys_clk_i);
    advance_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  task automatic st(input int w1, input int w2);
    rd(HSP_OFS_STATUS, 33'((w2 << 4) | w1), 33'h0_0000_00FF);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    seed_v = $urandom(32'hea91);
    wp = '{4'h0, 4'h0};
    last = HSP_PAT_RESET;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(HSP_OFS_MODE, 33'h0);
    st(0, 0);
    rd(HSP_OFS_BANK1_PAT_BUF, 33'h0);
    rd(8'h1C, 33'h1_0000_0000, 33'h1_0000_0000);
    p = 16'($urandom);
    wr(HSP_OFS_LOOP_STAGE_COUNT, {24'h0, p[7:0]});
    rd(HSP_OFS_LOOP_STAGE_COUNT, {25'h0, p[7:0]}, 33'h0_0000_00FF);
    $display("test registers done");
    wr(HSP_OFS_LOOP_STAGE_COUNT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      p = 16'($urandom);
      p[HSP_PAT_STROBE_BIT] = (i != 1);
      load(0, p, i == 0);
    end
    st(3, 0);
    for (int i = 0; i < 4; i++) play(i < 3 ? mem[0][i] : last, 1'b0, 0, i < 3 ? i + 1 : 3);
    $display("test single done");
    wr(HSP_OFS_LOOP_STAGE_COUNT, 32'h25);
    mode(3'h5, 1'b0);
    for (int i = 0; i < 4; i++) load(1, 16'($urandom), 1'b0);
    st(0, 4);
    for (int i = 0; i < 7; i++) play(mem[1][i % 3], 1'b0, 1, (i + 1) % 3);
    mode(3'h4, 1'b1);
    st(0, 0);
    play(last, 1'b0, 1, 0);
    $display("test loop bank2 done");
    // longest bank 1 loop, full bank, match source
    wr(HSP_OFS_LOOP_STAGE_COUNT, 32'h09);
    mode(3'h3, 1'b0);
    for (int i = 0; i < 11; i++) load(0, 16'($urandom), 1'b0);
    st(10, 0);
    for (int i = 0; i < 11; i++) play(mem[0][i % 10], 1'b1, 0, (i + 1) % 10);
    $display("test loop bank1 done");
    repeat (6) @(posedge sys_clk_i);
    wrap_up();
  end
endmodule
